// ==== verilog/adf_pkg.sv ====
package adf_pkg;
  // Register byte offsets
  localparam logic [7:0] ADF_CTRL_OFS  = 8'h00;
  localparam logic [7:0] ADF_CH0_OFS   = 8'h04;
  localparam logic [7:0] ADF_CH1_OFS   = 8'h08;
  localparam logic [7:0] ADF_STAT_OFS  = 8'h0C;
  localparam logic [7:0] ADF_DATA0_OFS = 8'h10;
  localparam logic [7:0] ADF_DATA1_OFS = 8'h14;
  // Field positions and widths
  localparam int ADF_OSR_LSB     = 0;
  localparam int ADF_CUT_LSB     = 4;
  localparam int ADF_FLD4_W      = 4;
  localparam int ADF_PH_LSB      = 0;
  localparam int ADF_PH_W        = 10;
  localparam int ADF_MUX_LSB     = 10;
  localparam int ADF_DIS_BIT     = 12;
  localparam int ADF_ST_FAST_LSB = 0;
  localparam int ADF_ST_PEND_LSB = 2;
  // Datapath sizes
  localparam int ADF_ACC_W  = 40;
  localparam int ADF_WORD_W = 24;
  localparam int ADF_CNT_W  = 14;
  localparam int ADF_HP_FRAC = 16;
  // Oversampling codes 0..8 stand for 64..16384
  localparam logic [3:0] ADF_OSR_MIN_LOG  = 4'h6;
  localparam logic [3:0] ADF_OSR_MAX_CODE = 4'h8;
  localparam logic [3:0] ADF_S3_MAX_LOG   = 4'hA;
  localparam logic [9:0] ADF_PH_MAX_HI    = 10'h1FF;
  localparam logic [1:0] ADF_FAST_CONV    = 2'h2;
  localparam logic [3:0] ADF_CUT_OFF      = 4'h0;
  // Output scaling: full scale 15 lands just under 2^23
  localparam int ADF_OUT_SHIFT = 19;
  localparam logic signed [4:0] ADF_FS_LEVEL   = 5'sh0F;
  localparam logic signed [4:0] ADF_TEST_LEVEL = 5'sh02;
  // Channel input selection
  typedef enum logic [1:0] {ADF_IN_NORMAL, ADF_IN_POS, ADF_IN_NEG, ADF_IN_ZERO} adf_insel_t;
endpackage

// ==== verilog/adf_chan.sv ====
`timescale 1ns/1ns
`default_nettype none
module adf_chan
  import adf_pkg::*;
(
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  reset,
  // Bitstream, settings and control from the window timer
  input  wire logic                  clear,
  input  wire logic                  mod_bit,
  input  wire logic [1:0]            input_sel,
  input  wire logic                  dump3,
  input  wire logic                  last,
  input  wire logic                  fast,
  input  wire logic [3:0]            log3,
  input  wire logic [3:0]            log1,
  // Conversion word
  output logic [ADF_WORD_W-1:0]      word,
  output logic                       done
);
  typedef struct packed {
    logic [ADF_ACC_W-1:0]  i1, i2, i3, c1, c2, c3, s1, f1;
    logic [ADF_WORD_W-1:0] word;
    logic                  done;
  } adf_chan_t;

  adf_chan_t s, n;
  logic signed [ADF_ACC_W-1:0] x, d1, d2, d3, acc;
  logic signed [63:0]          p;
  logic [5:0]                  sh;

  // Input multiplexer: bitstream or internal test level
  always_comb begin
    case (adf_insel_t'(input_sel))
      ADF_IN_NORMAL: x = mod_bit ? ADF_ACC_W'(ADF_FS_LEVEL) : -ADF_ACC_W'(ADF_FS_LEVEL);
      ADF_IN_POS:    x = ADF_ACC_W'(ADF_TEST_LEVEL);
      ADF_IN_NEG:    x = -ADF_ACC_W'(ADF_TEST_LEVEL);
      default:       x = '0;
    endcase
  end

  // Integrators run every modulator cycle; wraparound is harmless in the comb
  always_comb begin
    n = s;
    d1 = '0;
    d2 = '0;
    d3 = '0;
    acc = '0;
    p = '0;
    sh = '0;
    n.done = 1'b0;
    n.i1 = s.i1 + x;
    n.i2 = s.i2 + s.i1;
    n.i3 = s.i3 + s.i2;
    n.f1 = s.f1 + x;
    if (dump3) begin
      d1 = s.i3 - s.c1;
      d2 = d1 - s.c2;
      d3 = d2 - s.c3;
      n.c1 = s.i3;
      n.c2 = d1;
      n.c3 = d2;
      n.s1 = s.s1 + d3;
    end
    if (last) begin
      // Normalise by the gain of the path in use
      acc = fast ? n.f1 : n.s1;
      sh = fast ? 6'(log3) + 6'(log1) : 6'(log3) * 6'h3 + 6'(log1);
      p = (64'(acc) <<< ADF_OUT_SHIFT) >>> sh;
      n.word = p[ADF_WORD_W-1:0];
      n.done = 1'b1;
      n.s1 = '0;
      n.f1 = '0;
    end
    if (clear) begin
      n = '0;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign word = s.word;
  assign done = s.done;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  done_from_last_a: assert property (s.done |-> $past(last && !clear))
    else $error("Channel word without window end");
  comb_latch_a: assert property (dump3 && !clear |=> s.c1 == $past(s.i3))
    else $error("Comb delay not loaded at dump");
  test_level_a: assert property (input_sel == ADF_IN_NEG |-> x == -ADF_ACC_W'(ADF_TEST_LEVEL))
    else $error("Negative test level not applied");
endmodule
`default_nettype wire

// ==== verilog/adf_filter.sv ====
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - Third-order sinc decimation up to 1024
// - Nonzero cutoff enables high-pass, zero bypasses
// - Per-channel high-pass disable bit
// - Cutoff k gives coefficient 2^-(k+1)
// - Input select picks positive/negative test level
// - Phase is signed 10-bit modulator cycles
// - Each word spans exactly OVERSAMPLING_RATIO samples
// - Equal phases give aligned windows
// - Phase shifts window; results delivered together
// - Above 1024: sinc3 at 1024, sinc1 rest
// - First two conversions after reset use sinc1 path
// - Saturate phase to OVERSAMPLING_RATIO half range
// - Phase settings move ready indication timing
module adf_filter
  import adf_pkg::*;
(
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  reset,
  // Register port
  input  wire logic [7:0]            reg_addr,
  input  wire logic [31:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic [31:0]                reg_rdata,
  // Modulator bitstreams, one per channel
  input  wire logic [1:0]            mod_bit,
  // Conversion results
  output logic                       conv_ready_flag,
  output logic [ADF_WORD_W-1:0]      ch0_data,
  output logic [ADF_WORD_W-1:0]      ch1_data
);
  typedef struct packed {
    logic [1:0]                   sync1, sync2;
    logic [3:0]                   oversampling_ratio, cut;
    logic [1:0][ADF_PH_W-1:0]     ph;
    logic [1:0][1:0]              mux;
    logic [1:0]                   dis;
    logic [ADF_CNT_W-1:0]         ref_cnt;
    logic [1:0][1:0]              nconv;
    logic [1:0]                   pend, clr;
    logic [1:0][ADF_WORD_W-1:0]   hold, data;
    logic [1:0][ADF_ACC_W-1:0]    mean;
    logic                         rdy;
    logic [31:0]                  rdata;
  } adf_main_t;

  adf_main_t s, n;
  logic [3:0]                   osr_c, log_tot, log3, log1;
  logic [ADF_CNT_W-1:0]         tot_mask, m3;
  logic [ADF_PH_W-1:0]          ph_hi;
  logic [1:0][ADF_PH_W-1:0]     phs;
  logic [1:0][ADF_CNT_W-1:0]    pos;
  logic [1:0]                   w_last, w_dump, fast, cdone;
  logic [1:0][ADF_WORD_W-1:0]   cw;
  logic signed [ADF_ACC_W-1:0]  hp_x, hp_diff;
  logic                         wr_ch;

  // Decimation ratios split between the sinc3 and sinc1 stages
  always_comb begin
    osr_c = (s.oversampling_ratio > ADF_OSR_MAX_CODE) ? ADF_OSR_MAX_CODE : s.oversampling_ratio;
    log_tot = osr_c + ADF_OSR_MIN_LOG;
    log3 = (log_tot > ADF_S3_MAX_LOG) ? ADF_S3_MAX_LOG : log_tot;
    log1 = log_tot - log3;
    tot_mask = ~({ADF_CNT_W{1'b1}} << log_tot);
    m3 = ~({ADF_CNT_W{1'b1}} << log3);
    // Half range, capped once the ratio passes 1024
    ph_hi = (log_tot > ADF_S3_MAX_LOG) ? ADF_PH_MAX_HI : ADF_PH_W'(tot_mask >> 1);
  end

  // Saturated phase and per-channel window position
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      phs[i] = s.ph[i];
      if ($signed(s.ph[i]) > $signed(ph_hi)) begin
        phs[i] = ph_hi;
      end else if ($signed(s.ph[i]) < -$signed(ph_hi) - 10'sh1) begin
        phs[i] = ~ph_hi;
      end
      // Signed cycle offset against the shared reference count
      pos[i] = (s.ref_cnt - ADF_CNT_W'($signed(phs[i]))) & tot_mask;
      w_last[i] = (pos[i] == tot_mask);
      w_dump[i] = ((pos[i] & m3) == m3);
      fast[i] = (s.nconv[i] < ADF_FAST_CONV);
    end
  end

  assign wr_ch = (reg_addr == ADF_CH1_OFS);

  // Register port, high-pass and result pairing
  always_comb begin
    n = s;
    hp_x = '0;
    hp_diff = '0;
    n.rdata = '0;
    n.rdy = 1'b0;
    n.clr = '0;
    n.sync1 = mod_bit;
    n.sync2 = s.sync1;
    n.ref_cnt = (s.ref_cnt + ADF_CNT_W'(1)) & tot_mask;
    // Filtered results of both channels
    for (int i = 0; i < 2; i++) begin
      if (cdone[i]) begin
        if (s.cut == ADF_CUT_OFF || s.dis[i]) begin
          n.hold[i] = cw[i];
        end else begin
          // Mean tracker uses a shift, so no multiplier is needed
          hp_x = {cw[i], {ADF_HP_FRAC{1'b0}}};
          hp_diff = hp_x - $signed(s.mean[i]);
          n.mean[i] = s.mean[i] + ADF_ACC_W'(hp_diff >>> (5'(s.cut) + 5'h1));
          n.hold[i] = cw[i] - s.mean[i][ADF_ACC_W-1:ADF_HP_FRAC];
        end
        n.pend[i] = 1'b1;
        if (fast[i]) begin
          n.nconv[i] = s.nconv[i] + 2'h1;
        end
      end
    end
    // Both channels hand over together, after the later window
    if (&n.pend) begin
      n.data = n.hold;
      n.rdy = 1'b1;
      n.pend = '0;
    end
    if (reg_wr) begin
      case (reg_addr)
        ADF_CTRL_OFS: begin
          n.oversampling_ratio = reg_wdata[ADF_OSR_LSB +: ADF_FLD4_W];
          n.cut = reg_wdata[ADF_CUT_LSB +: ADF_FLD4_W];
          if (n.oversampling_ratio != s.oversampling_ratio || n.cut != s.cut) begin
            n.clr = '1;
          end
          if (n.oversampling_ratio != s.oversampling_ratio) begin
            n.ref_cnt = '0;
          end
        end
        ADF_CH0_OFS, ADF_CH1_OFS: begin
          n.ph[wr_ch] = reg_wdata[ADF_PH_LSB +: ADF_PH_W];
          n.mux[wr_ch] = reg_wdata[ADF_MUX_LSB +: 2];
          n.dis[wr_ch] = reg_wdata[ADF_DIS_BIT];
          if (n.ph[wr_ch] != s.ph[wr_ch] || n.mux[wr_ch] != s.mux[wr_ch]) begin
            n.clr[wr_ch] = 1'b1;
          end
        end
        default: ;
      endcase
    end
    // Restart drops half-finished pairs and the tracked mean
    for (int i = 0; i < 2; i++) begin
      if (n.clr[i]) begin
        n.pend[i] = 1'b0;
        n.mean[i] = '0;
      end
    end
    if (reg_rd) begin
      case (reg_addr)
        ADF_CTRL_OFS: begin
          n.rdata[ADF_OSR_LSB +: ADF_FLD4_W] = s.oversampling_ratio;
          n.rdata[ADF_CUT_LSB +: ADF_FLD4_W] = s.cut;
        end
        ADF_CH0_OFS, ADF_CH1_OFS: begin
          n.rdata[ADF_PH_LSB +: ADF_PH_W] = s.ph[wr_ch];
          n.rdata[ADF_MUX_LSB +: 2] = s.mux[wr_ch];
          n.rdata[ADF_DIS_BIT] = s.dis[wr_ch];
        end
        ADF_STAT_OFS: begin
          n.rdata[ADF_ST_FAST_LSB +: 2] = fast;
          n.rdata[ADF_ST_PEND_LSB +: 2] = s.pend;
        end
        ADF_DATA0_OFS: n.rdata[ADF_WORD_W-1:0] = s.data[0];
        ADF_DATA1_OFS: n.rdata[ADF_WORD_W-1:0] = s.data[1];
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // One decimator per channel, steered by its own window
  for (genvar g = 0; g < 2; g++) begin : g_ch
    adf_chan adf_chan_i (
      .ref_clk   (ref_clk),
      .reset     (reset),
      .clear     (s.clr[g]),
      .mod_bit   (s.sync2[g]),
      .input_sel (s.mux[g]),
      .dump3     (w_dump[g]),
      .last      (w_last[g]),
      .fast      (fast[g]),
      .log3      (log3),
      .log1      (log1),
      .word      (cw[g]),
      .done      (cdone[g])
    );
  end

  assign reg_rdata = s.rdata;
  assign conv_ready_flag = s.rdy;
  assign ch0_data = s.data[0];
  assign ch1_data = s.data[1];

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  ref_wrap_a: assert property (s.ref_cnt == tot_mask && !reg_wr |=> s.ref_cnt == '0)
    else $error("Reference count did not wrap at OVERSAMPLING_RATIO");
  zero_align_a: assert property (phs[0] == phs[1] |-> w_last[0] == w_last[1])
    else $error("Equal phases but windows differ");
  phase_limit_a: assert property ($signed(phs[1]) <= $signed(ph_hi))
    else $error("Phase above saturation limit");
  ready_cause_a: assert property (s.rdy |-> $past(cdone[0] || cdone[1]))
    else $error("Ready without a channel completion");
  hp_bypass_a: assert property (cdone[0] && s.dis[0] |=> s.hold[0] == $past(cw[0]))
    else $error("Disabled channel was filtered");
  hp_math_a: assert property (cdone[1] && s.cut != ADF_CUT_OFF && !s.dis[1]
    |=> s.hold[1] == $past(cw[1]) - $past(s.mean[1][ADF_ACC_W-1:ADF_HP_FRAC]))
    else $error("High-pass output mismatch");
  fast_count_a: assert property (s.nconv[0] <= ADF_FAST_CONV)
    else $error("Fast conversion count overran");
  restart_a: assert property (reg_wr && reg_addr == ADF_CH0_OFS
    && reg_wdata[ADF_PH_W-1:0] != s.ph[0] |=> s.clr[0])
    else $error("Phase change did not restart channel");
  read_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("Read data outside read slot");

  ready_fast_c: cover property (s.rdy && s.nconv[0] == ADF_FAST_CONV);
  ready_phase_c: cover property (s.rdy && phs[0] != phs[1]);
  hp_active_c: cover property (cdone[0] && s.cut != ADF_CUT_OFF && !s.dis[0]);
endmodule
`default_nettype wire

// ==== tb/adf_mod_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// Behavioural modulator pair standing in front of the filter
module adf_mod_model (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset,
  // Per channel: bit 1 picks alternating, else bit 0 is the constant level
  input  wire logic [3:0] pattern,
  // Bitstreams toward the filter
  output logic      [1:0] mod_bit
);
  logic toggle_reg;
  // Toggles just after each edge, like a real modulator output
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      toggle_reg <= 1'b0;
    end else begin
      toggle_reg <= ~toggle_reg;
    end
  end
  // Alternating averages to zero only over even window lengths
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      mod_bit[c] = pattern[2*c+1] ? toggle_reg : pattern[2*c];
    end
  end
endmodule
`default_nettype wire

// ==== tb/adf_decimation_dcblock_phase_tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module adf_decimation_dcblock_phase_tb_top
  import adf_pkg::*;
();
  // Positive and negative full scale 15, both scaled by 2^19
  localparam logic [31:0] W_POS = 32'h0078_0000;
  localparam logic [31:0] W_NEG = 32'h0088_0000;
  // Clock, reset and register port
  logic                  ref_clk;
  logic                  reset;
  logic [7:0]            reg_addr;
  logic [31:0]           reg_wdata;
  logic                  reg_wr;
  logic                  reg_rd;
  logic [31:0]           reg_rdata;
  // Streams and results
  logic [3:0]            pattern;
  logic [1:0]            mod_bit;
  logic                  conv_ready_flag;
  logic [ADF_WORD_W-1:0] ch0_data;
  logic [ADF_WORD_W-1:0] ch1_data;
  // Bookkeeping
  int                    n_fail;
  int                    n_checks;
  int                    cyc;
  int                    t0;
  logic [31:0]           v;
  typedef struct packed {
    logic [7:0]  a;
    logic [31:0] w;
    logic [31:0] e;
  } adf_row_t;
  // Write then read back; upper bits read 0, unmapped places ignore writes
  adf_row_t rows [7] = '{
    '{ADF_CTRL_OFS, 32'hFFFF_FF17, 32'h0000_0017},
    '{ADF_CH0_OFS, 32'hFFFF_FFFF, 32'h0000_1FFF},
    '{ADF_CH1_OFS, 32'h0000_0A5A, 32'h0000_0A5A},
    '{8'h18, 32'h1234_5678, 32'h0000_0000},
    '{ADF_CTRL_OFS, 32'h0000_0000, 32'h0000_0000},
    '{ADF_CH0_OFS, 32'h0000_0000, 32'h0000_0000},
    '{ADF_CH1_OFS, 32'h0000_0000, 32'h0000_0000}};
  logic [9:0]            ph_raw [4] = '{10'h020, 10'h064, 10'h200, 10'h3FF};
  int                    ph_exp [4] = '{32, 63, 64, 127};

  adf_filter adf_filter_i (
    .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mod_bit(mod_bit),
    .conv_ready_flag(conv_ready_flag), .ch0_data(ch0_data), .ch1_data(ch1_data));
  adf_mod_model adf_mod_model_i (
    .ref_clk(ref_clk), .reset(reset), .pattern(pattern), .mod_bit(mod_bit));

  // 125 MHz clock and a cycle count that restarts with reset
  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cyc <= 0;
    end else begin
      cyc <= cyc + 1;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // The watchdog bounds this wait if the flag never comes
  task automatic wait_rdy(input int n);
    for (int i = 0; i < n; i++) begin
      do begin
        @(posedge ref_clk);
        #1;
      end while (conv_ready_flag !== 1'b1);
    end
  endtask
  task automatic both(input logic [31:0] e0, input logic [31:0] e1);
    chk({8'h00, ch0_data}, e0, "ch0 data");
    chk({8'h00, ch1_data}, e1, "ch1 data");
  endtask
  task automatic results;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge ref_clk);
    n_fail++;
    $display("Error at %0t: watchdog expired", $time);
    results;
  end

  initial begin
    ref_clk = 1'b0;
    reset = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    pattern = 4'h1;
    n_fail = 0;
    n_checks = 0;
    repeat (5) @(posedge ref_clk);
    #1 both(32'h0, 32'h0);
    @(posedge ref_clk);
    reset <= 1'b0;
    rd(ADF_CH0_OFS, v);
    chk(v, 32'h0, "cfg reset");
    rd(ADF_STAT_OFS, v);
    chk(v, 32'h3, "fast after reset");
    wait_rdy(1);
    chk({31'h0, cyc >= 64 && cyc <= 66}, 32'h1, "first ready time");
    chk({8'h00, ch1_data}, W_NEG, "first fast word");
    t0 = cyc;
    @(posedge ref_clk);
    #1 chk({31'h0, conv_ready_flag}, 32'h0, "ready pulse");
    wait_rdy(1);
    chk(cyc - t0, 32'd64, "period");
    both(W_POS, W_NEG);
    wait_rdy(1);
    rd(ADF_STAT_OFS, v);
    chk(v & 32'h3, 32'h0, "fast path left");
    $display("reset and start-up test done");
    // Ordinary register cases
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, v);
      chk(v, rows[i].e, "register");
    end
    $display("register test done");
    pattern <= 4'h5;
    wait_rdy(5);
    both(W_POS, W_POS);
    // Test levels replace channel 0 only; channel 1 keeps its input
    for (int s = 1; s < 4; s++) begin
      wr(ADF_CH0_OFS, 32'(s) << ADF_MUX_LSB);
      wait_rdy(5);
      both((s == 1) ? 32'h0010_0000 : (s == 2) ? 32'h00F0_0000 : 32'h0, W_POS);
    end
    wr(ADF_CH0_OFS, 32'h0);
    $display("input select test done");
    // Smallest coefficient barely moves the word; channel 1 opts out
    wr(ADF_CH1_OFS, 32'h1 << ADF_DIS_BIT);
    wr(ADF_CTRL_OFS, 32'h0000_00F0);
    wait_rdy(10);
    chk({31'h0, ch0_data > 24'h77E000 && ch0_data < 24'h780000}, 32'h1, "k15");
    chk({8'h00, ch1_data}, W_POS, "hp disabled");
    wr(ADF_CTRL_OFS, 32'h0000_0010);
    wait_rdy(100);
    chk({31'h0, $signed(ch0_data) <= 8 && $signed(ch0_data) >= -8}, 32'h1, "k1");
    chk({8'h00, ch1_data}, W_POS, "hp disabled");
    wr(ADF_CTRL_OFS, 32'h0);
    wr(ADF_CH1_OFS, 32'h0);
    wait_rdy(5);
    both(W_POS, W_POS);
    $display("high-pass test done");
    // Equal phases on both channels move the ready moment by the clipped phase
    wr(ADF_CTRL_OFS, 32'h1);
    wait_rdy(4);
    t0 = cyc % 128;
    foreach (ph_raw[i]) begin
      wr(ADF_CH0_OFS, {22'h0, ph_raw[i]});
      wr(ADF_CH1_OFS, {22'h0, ph_raw[i]});
      wait_rdy(4);
      chk((cyc - t0 + 128) % 128, ph_exp[i], "phase shift");
    end
    wr(ADF_CH0_OFS, 32'h0);
    wr(ADF_CH1_OFS, 32'h020);
    wait_rdy(4);
    t0 = cyc;
    wait_rdy(1);
    chk(cyc - t0, 32'd128, "offset period");
    both(W_POS, W_POS);
    wr(ADF_CH1_OFS, 32'h0);
    $display("phase test done");
    // Window lengths per oversampling code, the last one through two stages
    for (int c = 0; c < 6; c++) begin
      wr(ADF_CTRL_OFS, 32'(c));
      wait_rdy(2);
      t0 = cyc;
      wait_rdy(1);
      chk(cyc - t0, 32'd64 << c, "osr period");
    end
    wait_rdy(4);
    both(W_POS, W_POS);
    $display("oversampling test done");
    results;
  end
endmodule
`default_nettype wire
